// ### logic/c7_op_decode.sv
// classifies a cache operations register access by opcode fields
// assumes the caller applies direction and privilege checks
`timescale 1ns/1ps
`include "cpop_consts.svh"

module c7_op_decode
  import cpop_pkg::*;
(
  input  wire logic       is_double,
  input  wire logic [2:0] opc1,
  input  wire logic [3:0] secondary_register_number,
  input  wire logic [2:0] opc2,
  output cpop_pkg::access_class_e cls
);

  // 23 single and 6 double transfer functions, 23 unified no-op encodings, rest undefined
  function automatic access_class_e decode_c7(input logic dbl, input logic [2:0] o1,
                                              input logic [3:0] m, input logic [2:0] o2);
    access_class_e c;
    c = CLS_UNDEF;
    if (dbl) begin
      if (o1 == `OPC1_0) begin
        if (m == `CRM_5 || m == `CRM_6 || m == `CRM_14) c = CLS_PRIV_WR;
        else if (m == `CRM_12) c = CLS_USER_WR;
      end else if (o1 == `OPC1_1) begin
        if (m == `CRM_5 || m == `CRM_6) c = CLS_USER_WR;
      end
    end else if (o1 == `OPC1_0) begin
      unique case (m)
        `CRM_0: if (o2 == `OP2_4) c = CLS_PRIV_WR;
        `CRM_5: begin
          if (o2 == `OP2_4) c = CLS_USER_WR;
          else if (o2 inside {`OP2_0, `OP2_1, `OP2_2, `OP2_6, `OP2_7}) c = CLS_PRIV_WR;
        end
        `CRM_6: if (o2 inside {`OP2_0, `OP2_1, `OP2_2}) c = CLS_PRIV_WR;
        // unified cache encodings act as no-operations here
        `CRM_7: c = (o2 == `OP2_0) ? CLS_PRIV_WR : CLS_UNIFIED;
        `CRM_10: begin
          if (o2 inside {`OP2_0, `OP2_1, `OP2_2}) c = CLS_PRIV_WR;
          else if (o2 inside {`OP2_4, `OP2_5}) c = CLS_USER_WR;
          else if (o2 == `OP2_6) c = CLS_PRIV_RD;
        end
        `CRM_11, `CRM_15: c = CLS_UNIFIED;
        `CRM_12: begin
          if (o2 == `OP2_4) c = CLS_USER_RD;
          else if (o2 == `OP2_5) c = CLS_USER_WR;
        end
        `CRM_13: if (o2 == `OP2_1) c = CLS_PRIV_WR;
        `CRM_14: if (o2 inside {`OP2_0, `OP2_1, `OP2_2}) c = CLS_PRIV_WR;
        default: c = CLS_UNDEF;
      endcase
    end
    return c;
  endfunction : decode_c7

  assign cls = decode_c7(is_double, opc1, secondary_register_number, opc2);

endmodule : c7_op_decode

// ### logic/cpop_consts.svh
// named constants for the fault address and cache operation access block
// assumes nothing beyond a SystemVerilog compiler
`ifndef CPOP_CONSTS_SVH
`define CPOP_CONSTS_SVH

// primary register numbers
`define CRN_FAULT_STATUS 4'h5
`define CRN_FAULT_ADDR   4'h6
`define CRN_CACHE_OPS    4'h7

// secondary register numbers
`define CRM_0  4'h0
`define CRM_5  4'h5
`define CRM_6  4'h6
`define CRM_7  4'h7
`define CRM_10 4'ha
`define CRM_11 4'hb
`define CRM_12 4'hc
`define CRM_13 4'hd
`define CRM_14 4'he
`define CRM_15 4'hf

// first opcode values
`define OPC1_0 3'h0
`define OPC1_1 3'h1

// second opcode values
`define OP2_0 3'h0
`define OP2_1 3'h1
`define OP2_2 3'h2
`define OP2_4 3'h4
`define OP2_5 3'h5
`define OP2_6 3'h6
`define OP2_7 3'h7

// register selections
`define OPC2_INSTRUCTION_FAULT_STATUS 3'h1
`define OPC2_FAR  3'h0
`define OPC2_WATCHPOINT_FAULT_ADDRESS 3'h1

// field layout and reset values
`define INSTRUCTION_FAULT_STATUS_ZERO_BIT 10
`define INSTRUCTION_FAULT_STATUS_STATUS_W 4
`define INSTRUCTION_FAULT_STATUS_RESET    32'h0000_0000
`define FAR_RESET     32'h0000_0000
`define WATCHPOINT_FAULT_ADDRESS_RESET    32'h0000_0000

// watchpoint address offsets per execution state
`define WP_OFS_FULL     32'h0000_0008
`define WP_OFS_COMPACT  32'h0000_0004
`define WP_OFS_BYTECODE 32'h0000_0000

`endif

// ### logic/cpop_pkg.sv
// types shared by the fault address and cache operation access block
// assumes cpop_consts.svh is on the include path
`include "cpop_consts.svh"

package cpop_pkg;

  typedef enum logic [5:0] {
    CLS_UNDEF   = 6'b00_0001,
    CLS_PRIV_WR = 6'b00_0010,
    CLS_PRIV_RD = 6'b00_0100,
    CLS_USER_WR = 6'b00_1000,
    CLS_USER_RD = 6'b01_0000,
    CLS_UNIFIED = 6'b10_0000
  } access_class_e;

  typedef enum logic [2:0] {
    EXEC_FULL     = 3'b001,
    EXEC_COMPACT  = 3'b010,
    EXEC_BYTECODE = 3'b100
  } exec_state_e;

  typedef struct packed {
    logic        valid;
    logic        is_read;
    logic        is_double;
    logic        privileged;
    logic [2:0]  opc1;
    logic [3:0]  primary_register_number;
    logic [3:0]  secondary_register_number;
    logic [2:0]  opc2;
    logic [31:0] wdata;
    logic [31:0] wdata2;
  } cp_req_s;

  typedef struct packed {
    logic        valid;
    logic        hit;
    logic        undef;
    logic [31:0] rdata;
  } cp_rsp_s;

  typedef struct packed {
    logic        valid;
    logic        is_double;
    logic [2:0]  opc1;
    logic [3:0]  secondary_register_number;
    logic [2:0]  opc2;
    logic [31:0] data;
    logic [31:0] data2;
  } c7_exec_s;

  typedef struct packed {
    logic                      precise_data_fault;
    logic [31:0]               data_mva;
    logic                      instr_fault;
    logic [`INSTRUCTION_FAULT_STATUS_STATUS_W-1:0] instr_status;
    logic                      watchpoint;
    logic [31:0]               watch_data_mva;
    logic [31:0]               watch_pc;
    exec_state_e               watch_state;
  } fault_ev_s;

  typedef struct packed {
    logic [31:0] instruction_fault_status;
    logic [31:0] far_v;
    logic [31:0] watchpoint_fault_address;
    cp_rsp_s     rsp;
    c7_exec_s    op;
  } state_s;

endpackage : cpop_pkg

// ### logic/fault_address_and_cache_op_access.sv
// fault status, fault address and watchpoint address registers, plus
// access checking of the cache operations register.
// assumes one request per cycle from the core, all inputs other than arst_n synchronous.
`timescale 1ns/1ps
`include "cpop_consts.svh"

module fault_address_and_cache_op_access
  import cpop_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  cpop_pkg::cp_req_s     req,
  input  cpop_pkg::fault_ev_s   ev,
  input  wire logic [31:0]      dirty_status,
  input  wire logic [31:0]      block_xfer_status,
  output cpop_pkg::cp_rsp_s     rsp,
  output cpop_pkg::c7_exec_s    c7_op
);

  state_s        st_q;
  state_s        st_d;
  access_class_e c7_cls;
  logic [31:0]   watch_addr;
  logic          sel_instruction_fault_status;
  logic          sel_far;
  logic          sel_watchpoint_fault_address;
  logic          sel_reg;
  logic          sel_c7;
  logic          c7_ok;
  logic          c7_exec;

  ////////////////////////////////////////////////////////////////////
  // helpers

  c7_op_decode u_decode (
    .is_double (req.is_double),
    .opc1      (req.opc1),
    .secondary_register_number       (req.secondary_register_number),
    .opc2      (req.opc2),
    .cls       (c7_cls)
  );

  watch_addr_calc u_watch (
    .pc    (ev.watch_pc),
    .state (ev.watch_state),
    .addr  (watch_addr)
  );

  ////////////////////////////////////////////////////////////////////
  // selection

  always_comb begin
    sel_instruction_fault_status = !req.is_double && req.primary_register_number == `CRN_FAULT_STATUS &&
               req.opc1 == `OPC1_0 && req.secondary_register_number == `CRM_0 && req.opc2 == `OPC2_INSTRUCTION_FAULT_STATUS;
    sel_far  = !req.is_double && req.primary_register_number == `CRN_FAULT_ADDR &&
               req.opc1 == `OPC1_0 && req.secondary_register_number == `CRM_0 && req.opc2 == `OPC2_FAR;
    sel_watchpoint_fault_address = !req.is_double && req.primary_register_number == `CRN_FAULT_ADDR &&
               req.opc1 == `OPC1_0 && req.secondary_register_number == `CRM_0 && req.opc2 == `OPC2_WATCHPOINT_FAULT_ADDRESS;
    sel_reg  = sel_instruction_fault_status || sel_far || sel_watchpoint_fault_address;
    // double transfers only ever address the cache operations register
    sel_c7   = req.is_double || req.primary_register_number == `CRN_CACHE_OPS;
  end

  // permission table per access class
  always_comb begin
    c7_ok   = 1'b0;
    c7_exec = 1'b0;
    unique case (c7_cls)
      CLS_PRIV_WR: c7_ok = !req.is_read && req.privileged;
      CLS_PRIV_RD: c7_ok = req.is_read && req.privileged;
      CLS_USER_WR: c7_ok = !req.is_read;
      CLS_USER_RD: c7_ok = req.is_read;
      CLS_UNIFIED: c7_ok = !req.is_read && req.privileged;
      default:     c7_ok = 1'b0;
    endcase
    // no double read exists
    if (req.is_double && req.is_read) c7_ok = 1'b0;
    c7_exec = c7_ok && !req.is_read && c7_cls != CLS_UNIFIED;
  end

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d     = st_q;
    st_d.rsp = '0;
    st_d.op  = '0;

    if (req.valid) begin
      st_d.rsp.valid = 1'b1;
      if (sel_reg) begin
        st_d.rsp.hit   = 1'b1;
        st_d.rsp.undef = !req.privileged;
        if (req.privileged && req.is_read) begin
          if (sel_instruction_fault_status) st_d.rsp.rdata = st_q.instruction_fault_status;
          if (sel_far)  st_d.rsp.rdata = st_q.far_v;
          if (sel_watchpoint_fault_address) st_d.rsp.rdata = st_q.watchpoint_fault_address;
        end
        if (req.privileged && !req.is_read) begin
          if (sel_instruction_fault_status) begin
            st_d.instruction_fault_status = req.wdata;
            st_d.instruction_fault_status[`INSTRUCTION_FAULT_STATUS_ZERO_BIT] = 1'b0;
          end
          if (sel_far)  st_d.far_v = req.wdata;
          if (sel_watchpoint_fault_address) st_d.watchpoint_fault_address  = req.wdata;
        end
      end else if (sel_c7) begin
        st_d.rsp.hit   = 1'b1;
        st_d.rsp.undef = !c7_ok;
        if (c7_ok && req.is_read) begin
          st_d.rsp.rdata = (c7_cls == CLS_PRIV_RD) ? dirty_status
                                                   : block_xfer_status;
        end
        if (c7_exec) begin
          st_d.op.valid     = 1'b1;
          st_d.op.is_double = req.is_double;
          st_d.op.opc1      = req.opc1;
          st_d.op.secondary_register_number       = req.secondary_register_number;
          st_d.op.opc2      = req.opc2;
          st_d.op.data      = req.wdata;
          st_d.op.data2     = req.wdata2;
        end
      end
    end

    // hardware events win over a software write in the same cycle
    if (ev.instr_fault) begin
      st_d.instruction_fault_status = {{(32 - `INSTRUCTION_FAULT_STATUS_STATUS_W){1'b0}}, ev.instr_status};
    end
    if (ev.watchpoint) begin
      st_d.far_v = ev.watch_data_mva;
      st_d.watchpoint_fault_address  = watch_addr;
    end
    // a precise data fault outranks a watchpoint for the fault address
    if (ev.precise_data_fault) begin
      st_d.far_v = ev.data_mva;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q       <= '0;
      st_q.instruction_fault_status  <= `INSTRUCTION_FAULT_STATUS_RESET;
      st_q.far_v <= `FAR_RESET;
      st_q.watchpoint_fault_address  <= `WATCHPOINT_FAULT_ADDRESS_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign rsp   = st_q.rsp;
  assign c7_op = st_q.op;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  property p_instruction_fault_status_read;
    req.valid && sel_instruction_fault_status && req.is_read && req.privileged
      |=> rsp.valid && !rsp.undef && rsp.rdata == $past(st_q.instruction_fault_status);
  endproperty
  a_instruction_fault_status_read: assert property (p_instruction_fault_status_read)
    else $error("instruction_fault_status read returned wrong data");

  property p_instruction_fault_status_write;
    req.valid && sel_instruction_fault_status && !req.is_read && req.privileged && !ev.instr_fault
      |=> st_q.instruction_fault_status[`INSTRUCTION_FAULT_STATUS_ZERO_BIT-1:0] == $past(req.wdata[`INSTRUCTION_FAULT_STATUS_ZERO_BIT-1:0]);
  endproperty
  a_instruction_fault_status_write: assert property (p_instruction_fault_status_write)
    else $error("instruction_fault_status write not loaded");

  property p_user_undef;
    req.valid && sel_reg && !req.privileged
      |=> rsp.valid && rsp.undef && ($stable(st_q.instruction_fault_status) || $past(ev.instr_fault));
  endproperty
  a_user_undef: assert property (p_user_undef)
    else $error("user access to fault register not trapped");

  property p_far_capture;
    ev.precise_data_fault |=> st_q.far_v == $past(ev.data_mva);
  endproperty
  a_far_capture: assert property (p_far_capture)
    else $error("fault address missed precise fault");

  property p_far_hold;
    !ev.precise_data_fault && !ev.watchpoint &&
      !(req.valid && sel_far && !req.is_read && req.privileged)
      |=> $stable(st_q.far_v);
  endproperty
  a_far_hold: assert property (p_far_hold)
    else $error("fault address changed without cause");

  property p_far_write;
    req.valid && sel_far && !req.is_read && req.privileged &&
      !ev.precise_data_fault && !ev.watchpoint
      |=> st_q.far_v == $past(req.wdata);
  endproperty
  a_far_write: assert property (p_far_write)
    else $error("fault address write lost");

  property p_far_watch;
    ev.watchpoint && !ev.precise_data_fault
      |=> st_q.far_v == $past(ev.watch_data_mva);
  endproperty
  a_far_watch: assert property (p_far_watch)
    else $error("watchpoint did not update fault address");

  property p_watchpoint_fault_address_full;
    ev.watchpoint && ev.watch_state == EXEC_FULL
      |=> st_q.watchpoint_fault_address == $past(ev.watch_pc) + `WP_OFS_FULL;
  endproperty
  a_watchpoint_fault_address_full: assert property (p_watchpoint_fault_address_full)
    else $error("watch address offset wrong in full state");

  property p_watchpoint_fault_address_compact;
    ev.watchpoint && ev.watch_state == EXEC_COMPACT
      |=> st_q.watchpoint_fault_address == $past(ev.watch_pc) + `WP_OFS_COMPACT;
  endproperty
  a_watchpoint_fault_address_compact: assert property (p_watchpoint_fault_address_compact)
    else $error("watch address offset wrong in compact state");

  property p_watchpoint_fault_address_write;
    req.valid && sel_watchpoint_fault_address && !req.is_read && req.privileged && !ev.watchpoint
      |=> st_q.watchpoint_fault_address == $past(req.wdata);
  endproperty
  a_watchpoint_fault_address_write: assert property (p_watchpoint_fault_address_write)
    else $error("watch address write lost");

  property p_priv_wr_read;
    req.valid && sel_c7 && c7_cls == CLS_PRIV_WR && (req.is_read || !req.privileged)
      |=> rsp.undef && !c7_op.valid;
  endproperty
  a_priv_wr_read: assert property (p_priv_wr_read)
    else $error("privileged cache operation not trapped");

  property p_dirty_read;
    req.valid && sel_c7 && c7_cls == CLS_PRIV_RD
      |=> rsp.undef == !$past(req.is_read && req.privileged);
  endproperty
  a_dirty_read: assert property (p_dirty_read)
    else $error("dirty status permission wrong");

  property p_user_wr;
    req.valid && sel_c7 && c7_cls == CLS_USER_WR && !req.is_read
      |=> c7_op.valid && !rsp.undef;
  endproperty
  a_user_wr: assert property (p_user_wr)
    else $error("user write operation not executed");

  property p_bts_read;
    req.valid && sel_c7 && c7_cls == CLS_USER_RD && req.is_read
      |=> !rsp.undef && rsp.rdata == $past(block_xfer_status);
  endproperty
  a_bts_read: assert property (p_bts_read)
    else $error("block transfer status read wrong");

  property p_unified;
    req.valid && sel_c7 && c7_cls == CLS_UNIFIED
      |=> !c7_op.valid && rsp.undef == !$past(req.privileged && !req.is_read);
  endproperty
  a_unified: assert property (p_unified)
    else $error("unified no-operation handled wrongly");

  property p_answer;
    req.valid |=> rsp.valid ##1 (rsp.valid == $past(req.valid));
  endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered next cycle");

  property p_instruction_fault_status_bit10;
    st_q.instruction_fault_status[`INSTRUCTION_FAULT_STATUS_ZERO_BIT] == 1'b0;
  endproperty
  a_instruction_fault_status_bit10: assert property (p_instruction_fault_status_bit10)
    else $error("instruction_fault_status bit ten set");

  property p_watchpoint_fault_address_bytecode;
    ev.watchpoint && ev.watch_state == EXEC_BYTECODE
      |=> st_q.watchpoint_fault_address == $past(ev.watch_pc) + `WP_OFS_BYTECODE;
  endproperty
  a_watchpoint_fault_address_bytecode: assert property (p_watchpoint_fault_address_bytecode)
    else $error("watch address offset wrong in bytecode state");

  property p_instruction_fault_status_capture;
    ev.instr_fault
      |=> st_q.instruction_fault_status[`INSTRUCTION_FAULT_STATUS_STATUS_W-1:0] == $past(ev.instr_status) &&
          st_q.instruction_fault_status[31:`INSTRUCTION_FAULT_STATUS_STATUS_W] == '0;
  endproperty
  a_instruction_fault_status_capture: assert property (p_instruction_fault_status_capture)
    else $error("instruction fault status not captured");

  property p_watchpoint_fault_address_hold;
    !ev.watchpoint &&
      !(req.valid && sel_watchpoint_fault_address && !req.is_read && req.privileged)
      |=> $stable(st_q.watchpoint_fault_address);
  endproperty
  a_watchpoint_fault_address_hold: assert property (p_watchpoint_fault_address_hold)
    else $error("watch address changed without cause");

  property p_unclaimed;
    req.valid && !sel_reg && !sel_c7
      |=> rsp.valid && !rsp.hit && !rsp.undef && rsp.rdata == '0;
  endproperty
  a_unclaimed: assert property (p_unclaimed)
    else $error("unclaimed request answered wrongly");

  property p_double_read;
    req.valid && req.is_double && req.is_read
      |=> rsp.undef && !c7_op.valid;
  endproperty
  a_double_read: assert property (p_double_read)
    else $error("double read not trapped");

  property p_op_copy;
    req.valid && sel_c7 && c7_exec
      |=> c7_op.valid && c7_op.is_double == $past(req.is_double) &&
          c7_op.data == $past(req.wdata) && c7_op.data2 == $past(req.wdata2) &&
          c7_op.secondary_register_number == $past(req.secondary_register_number) && c7_op.opc2 == $past(req.opc2);
  endproperty
  a_op_copy: assert property (p_op_copy)
    else $error("cache operation fields not passed on");

  property p_write_no_rdata;
    req.valid && !req.is_read
      |=> rsp.rdata == '0;
  endproperty
  a_write_no_rdata: assert property (p_write_no_rdata)
    else $error("write answered with read data");

endmodule : fault_address_and_cache_op_access

// ### logic/watch_addr_calc.sv
// watchpoint address adjustment by execution state
// assumes the pipeline presents the triggering instruction address
`timescale 1ns/1ps
`include "cpop_consts.svh"

module watch_addr_calc
  import cpop_pkg::*;
(
  input  wire logic [31:0]         pc,
  input  cpop_pkg::exec_state_e    state,
  output logic      [31:0]         addr
);

  always_comb begin
    unique case (state)
      EXEC_FULL:     addr = pc + `WP_OFS_FULL;
      EXEC_COMPACT:  addr = pc + `WP_OFS_COMPACT;
      EXEC_BYTECODE: addr = pc + `WP_OFS_BYTECODE;
      // illegal state code: leave the address untouched
      default:       addr = pc;
    endcase
  end

endmodule : watch_addr_calc

// ### verif/core_pipe_model.sv
// stand-in for the core pipeline: issues coprocessor transfers and fault events
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/1ps

module core_pipe_model
  import cpop_pkg::*;
#(
  parameter logic [31:0] DIRTY_VAL = 32'h0000_00a5,
  parameter logic [31:0] BLOCK_VAL = 32'h0000_005a
)(
  input  wire logic           clk,
  output cpop_pkg::cp_req_s   req,
  output cpop_pkg::fault_ev_s ev,
  output logic [31:0]         dirty_status,
  output logic [31:0]         block_xfer_status
);
  cp_req_s last_req;

  assign dirty_status      = DIRTY_VAL;
  assign block_xfer_status = BLOCK_VAL;

  initial begin
    req      = '0;
    ev       = '0;
    last_req = '0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // one whole transfer per request, all fields in one beat
  task automatic send(input cp_req_s r);
    @(posedge clk);
    req <= r;
    last_req = r;
  endtask : send

  // released fields flip so a stale value never passes for a held one
  task automatic quiet();
    cp_req_s idle;
    idle       = cp_req_s'(~last_req);
    idle.valid = 1'b0;
    @(posedge clk);
    req <= idle;
  endtask : quiet

  // one-cycle event pulse; released data fields flip with all event strobes cleared
  task automatic pulse(input fault_ev_s e);
    fault_ev_s idle;
    idle                    = fault_ev_s'(~e);
    idle.precise_data_fault = 1'b0;
    idle.instr_fault        = 1'b0;
    idle.watchpoint         = 1'b0;
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= idle;
  endtask : pulse
endmodule : core_pipe_model

// ### verif/fault_address_and_cache_op_access_tb_top.sv
// self-checking bench for the fault address and cache operation access block
// assumes cpop_pkg and core_pipe_model are compiled first
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin \
  miscompares++; $display("unexpected %s exp %h got %h", nm, (exp), (got)); end end

module fault_address_and_cache_op_access_tb_top
  import cpop_pkg::*;
;
  localparam logic [31:0] DV = 32'h0000_00a5;
  localparam logic [31:0] BV = 32'h0000_005a;

  typedef struct packed {
    logic        rd, dbl, pv;
    logic [2:0]  o1;
    logic [3:0]  n, m;
    logic [2:0]  o2;
    logic [31:0] wd, xr;
    logic        h, u, op;
  } row_s;

  logic        clk;
  logic        arst_n;
  cp_req_s     req;
  fault_ev_s   ev;
  logic [31:0] dirty_status;
  logic [31:0] block_xfer_status;
  cp_rsp_s     rsp;
  c7_exec_s    c7_op;
  int          miscompares;
  int          total_checks;
  row_s        rows[$];

  core_pipe_model #(.DIRTY_VAL(DV), .BLOCK_VAL(BV)) core (
    .clk(clk), .req(req), .ev(ev),
    .dirty_status(dirty_status), .block_xfer_status(block_xfer_status));

  fault_address_and_cache_op_access uut (
    .clk(clk), .arst_n(arst_n), .req(req), .ev(ev), .dirty_status(dirty_status),
    .block_xfer_status(block_xfer_status), .rsp(rsp), .c7_op(c7_op));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  function automatic cp_req_s to_req(input row_s x);
    cp_req_s r;
    r = '{1'b1, x.rd, x.dbl, x.pv, x.o1, x.n, x.m, x.o2, x.wd, ~x.wd};
    return r;
  endfunction : to_req

  task automatic check_rsp(input row_s x);
    `CHK("rsp_valid", 1'b1, rsp.valid)
    `CHK("hit", x.h, rsp.hit)
    `CHK("undef", x.u, rsp.undef)
    `CHK("rdata", x.xr, rsp.rdata)
    `CHK("op_valid", x.op, c7_op.valid)
    if (x.op) begin
      `CHK("op_data", x.wd, c7_op.data)
      `CHK("op_dbl", x.dbl, c7_op.is_double)
      `CHK("op_data2", ~x.wd, c7_op.data2)
      `CHK("op_opc1", x.o1, c7_op.opc1)
      `CHK("op_crm", x.m, c7_op.secondary_register_number)
      `CHK("op_opc2", x.o2, c7_op.opc2)
    end
  endtask : check_rsp

  task automatic run_row(input row_s x);
    core.send(to_req(x));
    core.quiet();
    #1;
    check_rsp(x);
  endtask : run_row

  initial begin
    #(5000 * 4);
    miscompares++;
    tally_and_finish();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    fault_ev_s   e;
    exec_state_e st[3];
    logic [31:0] ofs[3];
    row_s        wr;
    st  = '{EXEC_FULL, EXEC_COMPACT, EXEC_BYTECODE};
    ofs = '{32'h0000_0008, 32'h0000_0004, 32'h0000_0000};
    miscompares  = 0;
    total_checks = 0;
    arst_n       = 1'b0;
    rows.push_back(row_s'{1,0,1,0,5,0,1,0,0,1,0,0});
    rows.push_back(row_s'{1,0,1,0,6,0,0,0,0,1,0,0});
    rows.push_back(row_s'{1,0,1,0,6,0,1,0,0,1,0,0});
    rows.push_back(row_s'{0,0,1,0,5,0,1,32'h0000_0005,0,1,0,0});
    rows.push_back(row_s'{1,0,1,0,5,0,1,0,32'h0000_0005,1,0,0});
    rows.push_back(row_s'{1,0,0,0,5,0,1,0,0,1,1,0});
    rows.push_back(row_s'{0,0,0,0,5,0,1,32'h0000_0009,0,1,1,0});
    rows.push_back(row_s'{1,0,1,0,5,0,1,0,32'h0000_0005,1,0,0});
    rows.push_back(row_s'{0,0,1,0,6,0,0,32'h1234_5678,0,1,0,0});
    rows.push_back(row_s'{1,0,1,0,6,0,0,0,32'h1234_5678,1,0,0});
    rows.push_back(row_s'{0,0,1,0,6,0,1,32'habcd_0000,0,1,0,0});
    rows.push_back(row_s'{1,0,1,0,6,0,1,0,32'habcd_0000,1,0,0});
    rows.push_back(row_s'{0,0,0,0,6,0,0,32'h0000_0001,0,1,1,0});
    rows.push_back(row_s'{1,0,1,1,6,0,1,0,0,0,0,0});
    rows.push_back(row_s'{1,0,1,0,5,0,0,0,0,0,0,0});
    rows.push_back(row_s'{0,0,1,0,7,0,4,0,0,1,0,1});
    rows.push_back(row_s'{1,0,1,0,7,0,4,0,0,1,1,0});
    rows.push_back(row_s'{0,0,0,0,7,5,0,0,0,1,1,0});
    rows.push_back(row_s'{0,0,1,0,7,14,2,32'h0000_0040,0,1,0,1});
    rows.push_back(row_s'{0,0,0,0,7,10,4,0,0,1,0,1});
    rows.push_back(row_s'{0,0,0,0,7,10,5,0,0,1,0,1});
    rows.push_back(row_s'{0,0,1,0,7,5,4,0,0,1,0,1});
    rows.push_back(row_s'{1,0,0,0,7,10,5,0,0,1,1,0});
    rows.push_back(row_s'{1,0,1,0,7,10,6,0,DV,1,0,0});
    rows.push_back(row_s'{1,0,0,0,7,10,6,0,0,1,1,0});
    rows.push_back(row_s'{0,0,1,0,7,10,6,0,0,1,1,0});
    rows.push_back(row_s'{1,0,0,0,7,12,4,0,BV,1,0,0});
    rows.push_back(row_s'{1,0,1,0,7,12,4,0,BV,1,0,0});
    rows.push_back(row_s'{0,0,0,0,7,12,4,0,0,1,1,0});
    rows.push_back(row_s'{0,0,1,0,7,7,3,0,0,1,0,0});
    rows.push_back(row_s'{0,0,1,0,7,11,0,0,0,1,0,0});
    rows.push_back(row_s'{0,0,1,0,7,15,7,0,0,1,0,0});
    rows.push_back(row_s'{0,0,0,0,7,15,7,0,0,1,1,0});
    rows.push_back(row_s'{0,0,0,0,7,7,1,0,0,1,1,0});
    rows.push_back(row_s'{0,0,1,0,7,1,0,0,0,1,1,0});
    rows.push_back(row_s'{0,1,1,0,7,5,0,32'h0000_0100,0,1,0,1});
    rows.push_back(row_s'{0,1,0,0,7,12,0,32'h0000_0200,0,1,0,1});
    rows.push_back(row_s'{0,1,0,1,7,5,0,32'h0000_0300,0,1,0,1});
    rows.push_back(row_s'{0,1,0,0,7,5,0,32'h0000_0400,0,1,1,0});
    rows.push_back(row_s'{1,1,1,0,7,5,0,0,0,1,1,0});
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      run_row(rows[i]);
    end
    $display("test table done");

    // write then read of the same register on adjacent edges
    wr = row_s'{0,0,1,0,6,0,0,32'h5555_aaaa,0,1,0,0};
    core.send(to_req(wr));
    core.send(to_req(row_s'{1,0,1,0,6,0,0,0,0,1,0,0}));
    #1;
    check_rsp(wr);
    core.quiet();
    #1;
    `CHK("b2b_rdata", 32'h5555_aaaa, rsp.rdata)
    $display("test back_to_back done");

    e = '0;
    e.precise_data_fault = 1'b1;
    e.data_mva           = 32'h0000_1000;
    core.pulse(e);
    run_row(row_s'{1,0,1,0,6,0,0,0,32'h0000_1000,1,0,0});
    e = '0;
    e.instr_fault  = 1'b1;
    e.instr_status = 4'hd;
    core.pulse(e);
    run_row(row_s'{1,0,1,0,5,0,1,0,32'h0000_000d,1,0,0});
    run_row(row_s'{1,0,1,0,6,0,0,0,32'h0000_1000,1,0,0});
    for (int i = 0; i < 3; i++) begin
      e = '0;
      e.watchpoint     = 1'b1;
      e.watch_pc       = 32'h0000_2000;
      e.watch_data_mva = 32'h0000_3000 + i;
      e.watch_state    = st[i];
      core.pulse(e);
      run_row(row_s'{1,0,1,0,6,0,1,0,32'h0000_2000 + ofs[i],1,0,0});
      run_row(row_s'{1,0,1,0,6,0,0,0,32'h0000_3000 + i,1,0,0});
    end
    $display("test events done");

    // second reset lands on the edge that answers a cache operation
    core.send(to_req(rows[15]));
    core.quiet();
    arst_n <= 1'b0;
    #1;
    `CHK("rst_rsp", 1'b0, rsp.valid)
    `CHK("rst_op", 1'b0, c7_op.valid)
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      run_row(rows[i]);
    end
    $display("test reset done");
    tally_and_finish();
  end
endmodule : fault_address_and_cache_op_access_tb_top
